// File: src/program_sequencer_control.sv
`timescale 1ns/1ps
// ****************************************
// program sequencer control
// ****************************************
module program_sequencer_control #(
	parameter int REPEAT_CYCLES = prog_seq_pkg::REPEAT_CYC
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CMD_VALID,
	input wire prog_seq_pkg::key_e CMD_KEY,
	input wire logic CMD_HELD,
	input wire prog_seq_pkg::mode_e MODE,
	input wire logic DISP_MEM,
	input wire logic X_CONST,
	input wire logic X_NEG,
	input wire logic [prog_seq_pkg::X_W-1:0] X_INT,
	input wire logic APPEND_VALID,
	input wire prog_seq_pkg::kind_e APPEND_KIND,
	input wire logic APPEND_HAS_LABEL,
	input wire logic [prog_seq_pkg::LBL_W-1:0] APPEND_LABEL,
	output prog_seq_pkg::seq_state_e STATE,
	output logic [prog_seq_pkg::LINE_W-1:0] LINE_INDICATOR,
	output logic LINE_BLANK,
	output logic [prog_seq_pkg::LINE_W-1:0] RETURN_LINE,
	output logic RETURN_VALID,
	output logic [prog_seq_pkg::CNT_W-1:0] PROG_LINES,
	output logic X_LOAD,
	output logic [prog_seq_pkg::LINE_W-1:0] X_LOAD_LINE,
	output logic START_FAULT,
	output logic JUMP_RANGE_WARNING,
	output logic STEP_END_WARNING,
	output logic CMD_ERROR,
	output logic ERROR_SHOWN,
	output logic TERMINATE_ENTRY
);
	import prog_seq_pkg::*;

	// ****************************************
	// memory and search
	// ****************************************
	prog_mem_if m ();
	line_store u_line_store (.clk(CLK_SYS), .rst(RST), .m(m.store));
	label_finder u_label_finder (.m(m.look));

	// ****************************************
	// decode
	// ****************************************
	seq_state_e next_state; // next sequencer state
	logic [LINE_W-1:0] next_prompt; // next edit prompt
	logic [LINE_W-1:0] next_ret; // next return line
	logic next_ret_v, next_blank, next_xload;
	logic next_sf, next_jw, next_sw, next_err, next_shown;
	logic next_term;
	logic [LINE_W-1:0] next_xline;
	logic held_rep; // held back key is repeating
	logic [31:0] rep_cnt; // repeat interval counter

	wire logic [LINE_W-1:0] end_line = LINE_W'(m.count);
	wire logic at_end = LINE_INDICATOR == end_line;
	wire logic [ENT_W-1:0] cur =
		m.ent[LINE_INDICATOR[PTR_W-1:0]];
	wire kind_e cur_kind = kind_e'(cur[KIND_LSB+:KIND_W]);
	wire logic [LINE_W-1:0] x_line = LINE_W'(X_INT);
	wire logic [LINE_W-1:0] after = LINE_INDICATOR + 10'h001;
	// jump target and label number checks
	wire logic x_jump_ok = X_CONST && !X_NEG
		&& X_INT <= JUMP_MAX;
	wire logic x_past = X_INT >= X_W'(m.count);
	wire logic x_lbl_ok = X_CONST && !X_NEG
		&& X_INT <= LABEL_MAX;
	// direct commands act only from idle
	wire logic idle_cmd = CMD_VALID && STATE == ST_IDLE;
	wire logic c_start = idle_cmd && CMD_KEY == K_START;
	wire logic c_run = idle_cmd && CMD_KEY == K_RUN;
	wire logic c_step = idle_cmd && CMD_KEY == K_STEP;
	wire logic c_jump = idle_cmd && CMD_KEY == K_JUMP;
	wire logic c_label = idle_cmd && CMD_KEY == K_LABEL;
	wire logic c_prev = idle_cmd && CMD_KEY == K_PREV;
	wire logic c_del = idle_cmd && CMD_KEY == K_DELETE;
	wire logic prev_bad = MODE == M_EXEC
		|| LINE_INDICATOR == FIRST_LINE;
	wire logic del_ok = c_del && MODE != M_EXEC
		&& !at_end;
	wire logic rep_fire = held_rep && CMD_HELD
		&& rep_cnt == 32'(REPEAT_CYCLES - 1)
		&& LINE_INDICATOR != FIRST_LINE;

	// memory control
	assign m.del_en = del_ok;
	assign m.del_idx = LINE_INDICATOR[PTR_W-1:0];
	assign m.wr_en = APPEND_VALID && STATE == ST_IDLE
		&& !CMD_VALID;
	assign m.wr_data = {APPEND_HAS_LABEL, APPEND_LABEL,
		APPEND_KIND};
	assign m.find_lbl = LBL_W'(X_INT);
	assign PROG_LINES = m.count;

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		next_state = STATE;
		next_prompt = LINE_INDICATOR;
		next_ret = RETURN_LINE;
		next_ret_v = RETURN_VALID;
		next_blank = LINE_BLANK;
		next_xload = 1'b0;
		next_xline = X_LOAD_LINE;
		next_sf = 1'b0;
		next_jw = 1'b0;
		next_sw = 1'b0;
		next_err = 1'b0;
		next_shown = 1'b0;
		next_term = 1'b0;
		if (c_start) begin
			if (m.count == '0) begin
				next_sf = 1'b1;
				next_err = 1'b1;
			end else begin
				next_state = ST_RUN;
				next_prompt = FIRST_LINE;
				next_ret_v = 1'b0;
				next_blank = 1'b0;
			end
		end else if (c_run) begin
			if (at_end) begin
				next_err = 1'b1;
			end else begin
				next_state = ST_RUN;
			end
		end else if (c_step) begin
			// no entry termination here
			if (at_end) begin
				next_sw = 1'b1;
			end else begin
				next_state = ST_STEP;
			end
		end else if (c_jump) begin
			if (!x_jump_ok) begin
				next_err = 1'b1;
			end else if (x_past) begin
				next_jw = 1'b1;
				next_prompt = end_line;
				next_blank = 1'b1;
			end else begin
				next_prompt = x_line;
				next_blank = 1'b0;
			end
		end else if (c_label) begin
			if (x_lbl_ok && m.find_hit) begin
				next_xload = 1'b1;
				next_xline = LINE_W'(m.find_idx);
			end else begin
				next_err = 1'b1;
			end
		end else if (c_prev) begin
			if (prev_bad) begin
				next_err = 1'b1;
				next_shown = DISP_MEM;
			end else begin
				next_prompt = LINE_INDICATOR - 10'h001;
				next_term = MODE == M_ENTRY;
				next_blank = 1'b0;
			end
		end else if (c_del) begin
			if (!del_ok) begin
				next_err = 1'b1;
				next_shown = DISP_MEM;
			end
		end else if (rep_fire) begin
			next_prompt = LINE_INDICATOR - 10'h001;
		end else if (STATE == ST_RUN && at_end) begin
			next_state = ST_IDLE;
		end else if (STATE == ST_RUN || STATE == ST_STEP) begin
			// one stored line per cycle
			next_prompt = after;
			if (STATE == ST_STEP) begin
				next_state = ST_IDLE;
			end
			case (cur_kind)
				KD_STOP: begin
					next_state = ST_IDLE;
					if (STATE == ST_STEP) begin
						next_prompt = LINE_INDICATOR;
					end
				end
				KD_RUN: begin
					next_state = ST_RUN;
				end
				KD_START: begin
					next_prompt = FIRST_LINE;
					next_ret_v = 1'b0;
				end
				KD_JUMP, KD_CALL: begin
					if (!x_jump_ok) begin
						next_err = 1'b1;
						next_state = ST_IDLE;
						next_prompt = LINE_INDICATOR;
					end else if (x_past) begin
						next_jw = 1'b1;
						next_prompt = end_line;
						next_blank = 1'b1;
						next_state = ST_IDLE;
					end else begin
						next_prompt = x_line;
						if (cur_kind == KD_CALL) begin
							next_ret = after;
							next_ret_v = 1'b1;
						end
					end
				end
				KD_RET: begin
					if (RETURN_VALID) begin
						next_prompt = RETURN_LINE;
						next_ret_v = 1'b0;
					end else begin
						next_err = 1'b1;
						next_state = ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			STATE <= ST_IDLE;
			LINE_INDICATOR <= FIRST_LINE;
			RETURN_LINE <= '0;
			RETURN_VALID <= 1'b0;
			LINE_BLANK <= 1'b0;
			X_LOAD_LINE <= '0;
		end else begin
			STATE <= next_state;
			LINE_INDICATOR <= next_prompt;
			RETURN_LINE <= next_ret;
			RETURN_VALID <= next_ret_v;
			LINE_BLANK <= next_blank;
			X_LOAD_LINE <= next_xline;
		end
	end

	// one-cycle event outputs
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			{X_LOAD, START_FAULT, JUMP_RANGE_WARNING} <= 3'h0;
			{STEP_END_WARNING, CMD_ERROR} <= 2'h0;
			{ERROR_SHOWN, TERMINATE_ENTRY} <= 2'h0;
		end else begin
			{X_LOAD, START_FAULT, JUMP_RANGE_WARNING} <=
				{next_xload, next_sf, next_jw};
			{STEP_END_WARNING, CMD_ERROR} <= {next_sw, next_err};
			{ERROR_SHOWN, TERMINATE_ENTRY} <=
				{next_shown, next_term};
		end
	end

	// held back key: repeat timer
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			held_rep <= 1'b0;
			rep_cnt <= '0;
		end else if (!CMD_HELD) begin
			held_rep <= 1'b0;
			rep_cnt <= '0;
		end else if (c_prev && !prev_bad) begin
			held_rep <= 1'b1;
			rep_cnt <= '0;
		end else if (held_rep) begin
			rep_cnt <= rep_fire ? '0 : rep_cnt + 32'h1;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence s_step_go;
		c_step && !at_end;
	endsequence
	sequence s_step_done;
		STATE == ST_STEP ##1 STATE != ST_STEP;
	endsequence

	a_start_run_zero: assert property (
		c_start && m.count != '0 |=> STATE == ST_RUN
			&& LINE_INDICATOR == FIRST_LINE && !RETURN_VALID)
		else $error("start did not run from line zero");
	a_start_empty_fault: assert property (
		c_start && m.count == '0 |=> START_FAULT
			&& STATE == ST_IDLE)
		else $error("start on empty memory not faulted");
	a_run_refused: assert property (
		c_run && at_end |=> CMD_ERROR && STATE == ST_IDLE)
		else $error("run at end not refused");
	a_jump_far_warn: assert property (
		c_jump && x_jump_ok && x_past |=> JUMP_RANGE_WARNING
			&& LINE_BLANK && at_end && STATE == ST_IDLE)
		else $error("far jump not warned");
	a_jump_direct_move: assert property (
		c_jump && x_jump_ok && !x_past |=>
			LINE_INDICATOR == $past(x_line) && STATE == ST_IDLE)
		else $error("direct jump wrong line");
	a_jump_bad_range: assert property (
		c_jump && !x_jump_ok |=> CMD_ERROR
			&& $stable(LINE_INDICATOR))
		else $error("bad jump target accepted");
	a_step_one_line: assert property (
		s_step_go |=> s_step_done)
		else $error("step did not finish in one line");
	a_step_end_warn: assert property (
		c_step && at_end |=> STEP_END_WARNING
			&& STATE == ST_IDLE)
		else $error("step at end not warned");
	a_prev_refused: assert property (
		c_prev && prev_bad |=> CMD_ERROR
			&& $stable(LINE_INDICATOR)
			&& ERROR_SHOWN == $past(DISP_MEM))
		else $error("bad back-line not refused");
	a_delete_keeps: assert property (
		c_del && !del_ok |=> CMD_ERROR && $stable(m.count))
		else $error("refused delete changed memory");
	a_label_check: assert property (
		c_label && !(x_lbl_ok && m.find_hit) |=> CMD_ERROR
			&& !X_LOAD)
		else $error("bad label lookup not faulted");
endmodule // program_sequencer_control

// File: include/prog_seq_pkg.sv
// Function
// - direct start in idle runs from line zero
// - stored start in run jumps to zero
// - stored start in step halts at zero
// - every start but a faulted one clears the return register
// - direct start with empty memory faults
// - jump past last line warns, blanks, idles
// - label lookup returns first matching line
// - label must be 0..99 and present
// - direct jump moves prompt, stays idle
// - stored jump in run continues there
// - stored jump in step moves prompt only
// - jump target must be 0..999 constant
// - run command executes stored lines in order
// - run at end or empty faults
// - step executes line, advances, goes idle
// - stop halts step, run switches to run
// - step at end line warns
// - step leaves numeric entry untouched
// - back one line, terminate entry, repeat held
// - back in execute or at zero faults
// - delete removes line, closes gap
// - delete in execute or at end faults
// - call loads return with next position
package prog_seq_pkg;
	// ****************************************
	// sizes and limits
	// ****************************************
	localparam int LINE_W = 10; // line numbers 0..999
	localparam int DEPTH = 32; // stored lines held
	localparam int PTR_W = 5; // memory index width
	localparam int CNT_W = 6; // line count width
	localparam int X_W = 14; // rounded x magnitude
	localparam int LBL_W = 7; // label number width
	localparam int KIND_W = 3; // line command kind
	localparam int ENT_W = 11; // one memory entry
	localparam int KIND_LSB = 0; // kind field position
	localparam int LBL_LSB = 3; // label field position
	localparam int HASL_BIT = 10; // label present bit
	localparam logic [X_W-1:0] JUMP_MAX = 14'h03e7;
	localparam logic [X_W-1:0] LABEL_MAX = 14'h0063;
	localparam logic [LINE_W-1:0] FIRST_LINE = 10'h000;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 250; // system clock rate
	localparam int REPEAT_MS = 100; // held-key repeat time
	localparam int REPEAT_CYC = REPEAT_MS * 1000 * CLK_MHZ;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN = 2'h1,
		ST_STEP = 2'h3
	} seq_state_e;
	typedef enum logic [2:0] {
		K_START = 3'h0,
		K_RUN = 3'h1,
		K_STEP = 3'h2,
		K_JUMP = 3'h3,
		K_LABEL = 3'h4,
		K_PREV = 3'h5,
		K_DELETE = 3'h6
	} key_e;
	typedef enum logic [2:0] {
		KD_PLAIN = 3'h0,
		KD_STOP = 3'h1,
		KD_RUN = 3'h2,
		KD_START = 3'h3,
		KD_JUMP = 3'h4,
		KD_CALL = 3'h5,
		KD_RET = 3'h6
	} kind_e;
	typedef enum logic [1:0] {
		M_EXEC = 2'h0,
		M_ENTRY = 2'h1,
		M_EDIT = 2'h2
	} mode_e;
endpackage

// File: include/prog_mem_if.sv
`timescale 1ns/1ps
// ****************************************
// program memory carrier
// ****************************************
interface prog_mem_if;
	import prog_seq_pkg::*;
	logic [ENT_W-1:0] ent [DEPTH]; // stored lines
	logic [CNT_W-1:0] count; // assigned lines
	logic wr_en; // append one line
	logic [ENT_W-1:0] wr_data; // appended entry
	logic del_en; // delete one line
	logic [PTR_W-1:0] del_idx; // line to delete
	logic [LBL_W-1:0] find_lbl; // label searched
	logic find_hit; // label found
	logic [PTR_W-1:0] find_idx; // first match
	modport store(input wr_en, wr_data, del_en, del_idx,
		output ent, count);
	modport look(input ent, count, find_lbl,
		output find_hit, find_idx);
	modport ctl(input ent, count, find_hit, find_idx,
		output wr_en, wr_data, del_en, del_idx, find_lbl);
endinterface

// File: src/line_store.sv
`timescale 1ns/1ps
// ****************************************
// line storage with close-up delete
// ****************************************
module line_store (
	input wire logic clk,
	input wire logic rst,
	prog_mem_if.store m
);
	import prog_seq_pkg::*;

	// per-line storage: shift up from the deleted line
	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		logic shift; // this line takes its successor
		logic load; // this line is the append slot
		logic [ENT_W-1:0] succ; // successor content
		assign shift = m.del_en && (PTR_W'(i) >= m.del_idx);
		assign load = m.wr_en && (m.count == CNT_W'(i));
		if (i == DEPTH - 1) begin : g_last
			assign succ = '0;
		end else begin : g_mid
			assign succ = m.ent[i+1];
		end
		always_ff @(posedge clk) begin
			if (rst) begin
				m.ent[i] <= '0;
			end else if (shift) begin
				m.ent[i] <= succ;
			end else if (load) begin
				m.ent[i] <= m.wr_data;
			end
		end
	end

	// line count: delete wins over append
	always_ff @(posedge clk) begin
		if (rst) begin
			m.count <= '0;
		end else if (m.del_en) begin
			m.count <= m.count - CNT_W'(1);
		end else if (m.wr_en && m.count < CNT_W'(DEPTH)) begin
			m.count <= m.count + CNT_W'(1);
		end
	end
endmodule // line_store

// File: src/label_finder.sv
`timescale 1ns/1ps
// ****************************************
// first-occurrence label search
// ****************************************
module label_finder (
	prog_mem_if.look m
);
	import prog_seq_pkg::*;

	logic [DEPTH-1:0] hit; // per-line match

	// one comparator per stored line
	for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
		assign hit[i] = m.ent[i][HASL_BIT]
			&& (m.ent[i][LBL_LSB+:LBL_W] == m.find_lbl)
			&& (CNT_W'(i) < m.count);
	end

	// lowest matching line wins
	always_comb begin
		m.find_idx = '0;
		for (int j = DEPTH - 1; j >= 0; j--) begin
			if (hit[j]) begin
				m.find_idx = PTR_W'(j);
			end
		end
	end
	assign m.find_hit = |hit;
endmodule // label_finder

// File: testbench/key_source.sv
`timescale 1ns/1ps
// ****************************************
// keypad and remote command source model
// ****************************************
module key_source (
	input wire logic clk,
	output logic cmd_valid,
	output prog_seq_pkg::key_e cmd_key,
	output logic cmd_held,
	output prog_seq_pkg::mode_e mode,
	output logic disp_mem,
	output logic x_const,
	output logic x_neg,
	output logic [prog_seq_pkg::X_W-1:0] x_int,
	output logic app_valid,
	output prog_seq_pkg::kind_e app_kind,
	output logic app_lbl_on,
	output logic [prog_seq_pkg::LBL_W-1:0] app_lbl
);
	import prog_seq_pkg::*;
	// quiet levels from time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_key = K_START;
		cmd_held = 1'b0;
		mode = M_EXEC;
		disp_mem = 1'b1;
		x_const = 1'b1;
		x_neg = 1'b0;
		x_int = 14'h0000;
		app_valid = 1'b0;
		app_kind = KD_PLAIN;
		app_lbl_on = 1'b0;
		app_lbl = 7'h00;
	end
	// one key stroke, then held for n more cycles
	task automatic press(input key_e k, input int n);
		@(negedge clk);
		cmd_key = k;
		cmd_valid = 1'b1;
		cmd_held = (n > 0);
		@(negedge clk);
		cmd_valid = 1'b0;
		repeat (n) @(negedge clk);
		cmd_held = 1'b0;
	endtask
	// append one stored line, label flag on top
	task automatic append(input kind_e k, input logic [LBL_W:0] l);
		@(negedge clk);
		app_kind = k;
		app_lbl_on = l[LBL_W];
		app_lbl = l[LBL_W-1:0];
		app_valid = 1'b1;
		@(negedge clk);
		app_valid = 1'b0;
	endtask
	// panel mode, display mode and x contents
	task automatic setup(input mode_e m, input logic d, input logic c,
		input logic ng, input logic [X_W-1:0] v);
		@(negedge clk);
		mode = m;
		disp_mem = d;
		x_const = c;
		x_neg = ng;
		x_int = v;
	endtask
endmodule // key_source

// File: testbench/tb.sv
`timescale 1ns/1ps
// ****************************************
// self-checking bench for the sequencer
// ****************************************
module tb;
	import prog_seq_pkg::*;
	// flag bits of an expected answer
	localparam logic [7:0] F_BL = 8'h80, F_XL = 8'h40, F_SF = 8'h20,
		F_JW = 8'h10, F_SW = 8'h08, F_CE = 8'h04, F_ES = 8'h02;
	logic clk = 1'b0, rst = 1'b1;
	logic cmd_valid, cmd_held, disp_mem, x_const, x_neg, app_valid;
	logic app_lbl_on, blank, ret_valid, x_load, start_fault, jump_warn;
	logic step_warn, cmd_error, err_shown, term_entry;
	key_e cmd_key;
	mode_e mode;
	kind_e app_kind;
	seq_state_e state;
	logic [X_W-1:0] x_int;
	logic [LBL_W-1:0] app_lbl, lb;
	logic [LINE_W-1:0] line, ret_line, x_load_line, t;
	logic [CNT_W-1:0] prog_lines;
	logic [59:0] notes[$]; // expected answer and care mask
	logic [59:0] want;
	int error_cnt = 0, n_tests = 0;
	kind_e kinds[8] = '{KD_PLAIN, KD_PLAIN, KD_PLAIN, KD_PLAIN, KD_STOP,
		KD_PLAIN, KD_START, KD_JUMP};
	// 250 MHz system clock
	initial begin
		forever #2 clk = ~clk;
	end
	key_source u_key_source (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_key(cmd_key), .cmd_held(cmd_held), .mode(mode),
		.disp_mem(disp_mem), .x_const(x_const), .x_neg(x_neg),
		.x_int(x_int), .app_valid(app_valid), .app_kind(app_kind),
		.app_lbl_on(app_lbl_on), .app_lbl(app_lbl));
	program_sequencer_control #(.REPEAT_CYCLES(4)) u_program_sequencer_control (
		.CLK_SYS(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_KEY(cmd_key),
		.CMD_HELD(cmd_held), .MODE(mode), .DISP_MEM(disp_mem),
		.X_CONST(x_const), .X_NEG(x_neg), .X_INT(x_int),
		.APPEND_VALID(app_valid), .APPEND_KIND(app_kind),
		.APPEND_HAS_LABEL(app_lbl_on), .APPEND_LABEL(app_lbl),
		.STATE(state), .LINE_INDICATOR(line), .LINE_BLANK(blank),
		.RETURN_LINE(ret_line), .RETURN_VALID(ret_valid),
		.PROG_LINES(prog_lines), .X_LOAD(x_load), .X_LOAD_LINE(x_load_line),
		.START_FAULT(start_fault), .JUMP_RANGE_WARNING(jump_warn),
		.STEP_END_WARNING(step_warn), .CMD_ERROR(cmd_error),
		.ERROR_SHOWN(err_shown), .TERMINATE_ENTRY(term_entry));
	// ****************************************
	// checking helpers
	// ****************************************
	task automatic give_verdict();
		$display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic compare(input logic [31:0] g, input logic [31:0] w);
		n_tests++;
		if (g !== w) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, w);
		end
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// expected answer: state, prompt, lookup line, flags; mask beside it
	function automatic logic [59:0] note(input seq_state_e st,
		input logic [9:0] ln, input logic [9:0] xl, input logic [7:0] f);
		logic [29:0] care;
		care = {12'hfff, {10{f[6]}}, f[7], 7'h7f};
		return {st, ln, xl, f, care};
	endfunction
	// answer stands from the taking edge until the next edge
	always @(posedge clk) begin
		if (cmd_valid === 1'b1) begin
			@(negedge clk);
			want = notes.pop_front();
			compare(32'({state, line, x_load_line, blank, x_load,
				start_fault, jump_warn, step_warn, cmd_error, err_shown,
				term_entry} & want[29:0]), 32'(want[59:30] & want[29:0]));
		end
	end
	// key stroke with its expected answer queued first
	task automatic cmd(input key_e k, input logic [59:0] n, input int h = 0);
		notes.push_back(n);
		u_key_source.press(k, h);
		repeat (2) @(negedge clk);
	endtask
	task automatic jump(input logic [9:0] v);
		u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, {4'h0, v});
		cmd(K_JUMP, note(ST_IDLE, v, 10'h000, 8'h00));
	endtask
	// bounded wait for a running line, or for idle
	task automatic wait_for(input logic run, input logic [9:0] v);
		int i;
		i = 0;
		while (i < 500 && !(run ? (state === ST_RUN && line === v)
			: state === ST_IDLE)) begin
			@(negedge clk);
			i++;
		end
		n_tests++;
		if (i == 500) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, line, v);
			give_verdict();
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h8d672cce));
		repeat (4) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		compare(32'({state, line, ret_valid}), 32'({ST_IDLE, 11'h000}));
		cmd(K_START, note(ST_IDLE, 10'h000, 10'h000, F_SF | F_CE));
		cmd(K_RUN, note(ST_IDLE, 10'h000, 10'h000, F_CE));
		done("empty");
		// eight lines: labels on 0 and 2, stop, start and jump kinds
		lb = 7'(10 + $urandom % 90);
		for (int i = 0; i < 8; i++)
			u_key_source.append(kinds[i], i == 0 ? 8'h87 : i == 2 ? {1'b1, lb} : 8'h00);
		t = 10'($urandom % 8);
		jump(t);
		u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, 14'(8 + $urandom % 992));
		cmd(K_JUMP, note(ST_IDLE, 10'h008, 10'h000, F_BL | F_JW));
		for (int i = 0; i < 3; i++) begin
			u_key_source.setup(M_EXEC, 1'b1, i != 2, i == 1, i == 0 ? 14'h03e8 : 14'h0003);
			cmd(K_JUMP, note(ST_IDLE, 10'h008, 10'h000, F_CE));
		end
		cmd(K_STEP, note(ST_IDLE, 10'h008, 10'h000, F_SW));
		cmd(K_RUN, note(ST_IDLE, 10'h008, 10'h000, F_CE));
		done("jump");
		u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, {7'h00, lb});
		cmd(K_LABEL, note(ST_IDLE, 10'h008, 10'h002, F_XL));
		u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, 14'h0007);
		cmd(K_LABEL, note(ST_IDLE, 10'h008, 10'h000, F_XL));
		for (int i = 0; i < 2; i++) begin
			u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, i ? 14'h0064 : 14'h0009);
			cmd(K_LABEL, note(ST_IDLE, 10'h008, 10'h000, F_CE));
		end
		done("label");
		// step a plain, a stop, a start and a jump line
		jump(10'h000);
		cmd(K_STEP, note(ST_STEP, 10'h000, 10'h000, 8'h00));
		compare(32'({state, line}), 32'({ST_IDLE, 10'h001}));
		jump(10'h004);
		cmd(K_STEP, note(ST_STEP, 10'h004, 10'h000, 8'h00));
		compare(32'({state, line}), 32'({ST_IDLE, 10'h004}));
		jump(10'h006);
		cmd(K_STEP, note(ST_STEP, 10'h006, 10'h000, 8'h00));
		compare(32'({state, line, ret_valid}), 32'({ST_IDLE, 11'h000}));
		jump(10'h007);
		u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, 14'h0001);
		cmd(K_STEP, note(ST_STEP, 10'h007, 10'h000, 8'h00));
		compare(32'({state, line}), 32'({ST_IDLE, 10'h001}));
		done("step");
		// run from line 5: stored start wraps to zero, stop halts
		jump(10'h005);
		cmd(K_RUN, note(ST_RUN, 10'h005, 10'h000, 8'h00));
		wait_for(1'b1, 10'h000);
		wait_for(1'b0, 10'h000);
		compare(32'(ret_valid), 32'h0);
		cmd(K_START, note(ST_RUN, 10'h000, 10'h000, 8'h00));
		wait_for(1'b0, 10'h000);
		jump(10'h007);
		u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, 14'h0005);
		// the jump target stands for one cycle only: watch from the strobe
		notes.push_back(note(ST_RUN, 10'h007, 10'h000, 8'h00));
		u_key_source.press(K_RUN, 0);
		wait_for(1'b1, 10'h005);
		wait_for(1'b0, 10'h000);
		done("run");
		// back one line: refused in execute and at zero, held repeats
		jump(10'h003);
		for (int d = 0; d < 2; d++) begin
			u_key_source.setup(M_EXEC, d[0], 1'b1, 1'b0, 14'h0003);
			cmd(K_PREV, note(ST_IDLE, 10'h003, 10'h000, F_CE | (d ? F_ES : 8'h00)));
		end
		u_key_source.setup(M_EDIT, 1'b1, 1'b1, 1'b0, 14'h0003);
		cmd(K_PREV, note(ST_IDLE, 10'h002, 10'h000, 8'h00));
		u_key_source.setup(M_ENTRY, 1'b1, 1'b1, 1'b0, 14'h0003);
		cmd(K_PREV, note(ST_IDLE, 10'h001, 10'h000, 8'h01));
		u_key_source.setup(M_EDIT, 1'b1, 1'b1, 1'b0, 14'h0003);
		cmd(K_PREV, note(ST_IDLE, 10'h000, 10'h000, 8'h00));
		cmd(K_PREV, note(ST_IDLE, 10'h000, 10'h000, F_CE | F_ES));
		jump(10'h003);
		u_key_source.setup(M_EDIT, 1'b1, 1'b1, 1'b0, 14'h0003);
		cmd(K_PREV, note(ST_IDLE, 10'h002, 10'h000, 8'h00), 40);
		compare(32'(line), 32'h0);
		done("back");
		// delete: refused in execute and at the end line, closes gap
		jump(10'h001);
		cmd(K_DELETE, note(ST_IDLE, 10'h001, 10'h000, F_CE | F_ES));
		u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, 14'h0008);
		cmd(K_JUMP, note(ST_IDLE, 10'h008, 10'h000, F_JW));
		u_key_source.setup(M_EDIT, 1'b1, 1'b1, 1'b0, 14'h0008);
		cmd(K_DELETE, note(ST_IDLE, 10'h008, 10'h000, F_CE | F_ES));
		compare(32'(prog_lines), 32'h8);
		jump(10'h001);
		u_key_source.setup(M_EDIT, 1'b1, 1'b1, 1'b0, {7'h00, lb});
		cmd(K_DELETE, note(ST_IDLE, 10'h001, 10'h000, 8'h00));
		compare(32'(prog_lines), 32'h7);
		u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, {7'h00, lb});
		cmd(K_LABEL, note(ST_IDLE, 10'h001, 10'h001, F_XL));
		done("delete");
		// call from line 7 to 9, return to 8, start clears it
		u_key_source.append(KD_CALL, 8'h00);
		u_key_source.append(KD_STOP, 8'h00);
		u_key_source.append(KD_RET, 8'h00);
		for (int i = 0; i < 2; i++) begin
			jump(10'h007);
			u_key_source.setup(M_EXEC, 1'b1, 1'b1, 1'b0, 14'h0009);
			cmd(K_STEP, note(ST_STEP, 10'h007, 10'h000, 8'h00));
			compare(32'({state, line, ret_valid, ret_line}),
				32'({ST_IDLE, 10'h009, 1'b1, 10'h008}));
			if (i == 0) begin
				cmd(K_STEP, note(ST_STEP, 10'h009, 10'h000, 8'h00));
				compare(32'({line, ret_valid}), 32'({10'h008, 1'b0}));
			end
		end
		cmd(K_START, note(ST_RUN, 10'h000, 10'h000, 8'h00));
		wait_for(1'b0, 10'h000);
		compare(32'(ret_valid), 32'h0);
		done("call");
		give_verdict();
	end
endmodule // tb
